// File: hdl/jrxc_top.sv
// receive lane error counting, alignment ramp check and dc test levels
//
// Contract
// - count three error kinds against 8-bit limit
// - limit reached raises irq, resync, or both
// - limit resets to 255, always readable/writable
// - counting and comparison independent per lane
// - lane enable bits, reset lanes 0-3 on
// - ramp check on: alignment data 00-01-02 ramp
// - ramp check off at reset, accept anything
// - dc test drives I from two bytes
// - dc test drives Q from two bytes
// - disparity resync bit requests resync at limit
`timescale 1ns/1ps
`default_nettype none
module jrxc_top (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire jrxc_pkg::jrxc_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    input wire jrxc_pkg::jrxc_lane_err_t lane_err_i,
    input wire logic [7:0] char_valid_i,
    input wire logic counter_clear_i,
    input wire logic [7:0] ilas_valid_i,
    input wire logic [7:0] ilas_first_i,
    input wire logic [63:0] ilas_data_i,
    input wire jrxc_pkg::jrxc_iq_t dp_data_i,
    output jrxc_pkg::jrxc_iq_t dp_data_o,
    output logic resync_request_out_o,
    output logic error_irq_o,
    output logic [7:0] ilas_fail_o,
    output logic link_start_ok_o
);
    import jrxc_pkg::*;

    // saturating increment, shared by all counters
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == CNT_MAX) ? v : v + 8'h01;
    endfunction

    // register file
    logic [2:0] sync_mask_q, sync_mask_d;
    logic cmm_en_q, cmm_en_d;
    logic [7:0] error_limit_q, error_limit_d;
    logic [7:0] lane_on_bits_q, lane_on_bits_d;
    logic ramp_verify_on_q, ramp_verify_on_d;
    logic constant_level_test_on_q, constant_level_test_on_d;
    logic dig_spare_q, dig_spare_d;
    logic [7:0] i_level_low_byte_q, i_level_low_byte_d;
    logic [7:0] i_level_high_byte_q, i_level_high_byte_d;
    logic [7:0] q_level_low_byte_q, q_level_low_byte_d;
    logic [7:0] q_level_high_byte_q, q_level_high_byte_d;
    logic [2:0] irq_en_q, irq_en_d;
    logic [7:0] rdata_q, rdata_d;

    // lane state
    logic [7:0] cnt_q [NKIND][NLANE];
    logic [7:0] cnt_d [NKIND][NLANE];
    logic [7:0] exp_q [NLANE];
    logic [7:0] exp_d [NLANE];
    logic [7:0] fail_q, fail_d;
    logic [NLANE-1:0] hit [NKIND];
    logic [7:0] lane_hit;
    logic resync_q, resync_d;
    logic irq_q, irq_d;
    logic start_ok_q, start_ok_d;
    jrxc_iq_t dp_q, dp_d;

    logic [2:0] sync_en;
    assign sync_en = {sync_mask_q[0], sync_mask_q[1], sync_mask_q[2]};

    always_comb begin
        sync_mask_d = sync_mask_q;
        cmm_en_d = cmm_en_q;
        error_limit_d = error_limit_q;
        lane_on_bits_d = lane_on_bits_q;
        ramp_verify_on_d = ramp_verify_on_q;
        constant_level_test_on_d = constant_level_test_on_q;
        dig_spare_d = dig_spare_q;
        i_level_low_byte_d = i_level_low_byte_q;
        i_level_high_byte_d = i_level_high_byte_q;
        q_level_low_byte_d = q_level_low_byte_q;
        q_level_high_byte_d = q_level_high_byte_q;
        irq_en_d = irq_en_q;
        rdata_d = rdata_q;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                OFF_SYNC_MASK: begin
                    sync_mask_d = reg_req_i.wdata[SYNC_DISP_BIT:SYNC_UCC_BIT];
                    cmm_en_d = reg_req_i.wdata[CMM_EN_BIT];
                end
                OFF_ERR_LIMIT: error_limit_d = reg_req_i.wdata;
                OFF_LANE_EN: lane_on_bits_d = reg_req_i.wdata;
                OFF_RAMP: ramp_verify_on_d = reg_req_i.wdata[RAMP_BIT];
                OFF_DIG_TEST: begin
                    constant_level_test_on_d = reg_req_i.wdata[DC_TEST_BIT];
                    dig_spare_d = reg_req_i.wdata[DIG_SPARE_BIT];
                end
                OFF_I_LO: i_level_low_byte_d = reg_req_i.wdata;
                OFF_I_HI: i_level_high_byte_d = reg_req_i.wdata;
                OFF_Q_LO: q_level_low_byte_d = reg_req_i.wdata;
                OFF_Q_HI: q_level_high_byte_d = reg_req_i.wdata;
                OFF_IRQ_EN: irq_en_d = reg_req_i.wdata[2:0];
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                OFF_SYNC_MASK: rdata_d = {sync_mask_q, 1'b0, cmm_en_q, 3'h0};
                OFF_ERR_LIMIT: rdata_d = error_limit_q;
                OFF_LANE_EN: rdata_d = lane_on_bits_q;
                OFF_RAMP: rdata_d = {7'h00, ramp_verify_on_q};
                OFF_DIG_TEST: rdata_d = {6'h00, constant_level_test_on_q, dig_spare_q};
                OFF_I_LO: rdata_d = i_level_low_byte_q;
                OFF_I_HI: rdata_d = i_level_high_byte_q;
                OFF_Q_LO: rdata_d = q_level_low_byte_q;
                OFF_Q_HI: rdata_d = q_level_high_byte_q;
                OFF_IRQ_EN: rdata_d = {5'h00, irq_en_q};
                OFF_ILAS_FAIL: rdata_d = fail_q;
                OFF_LIMIT_HIT: rdata_d = lane_hit;
                default: rdata_d = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_mask_q <= 3'h0;
            cmm_en_q <= RST_CMM_EN;
            error_limit_q <= RST_ERR_LIMIT;
            lane_on_bits_q <= RST_LANE_EN;
            ramp_verify_on_q <= 1'b0;
            constant_level_test_on_q <= 1'b0;
            dig_spare_q <= 1'b0;
            i_level_low_byte_q <= RST_ZERO;
            i_level_high_byte_q <= RST_ZERO;
            q_level_low_byte_q <= RST_ZERO;
            q_level_high_byte_q <= RST_ZERO;
            irq_en_q <= 3'h0;
            rdata_q <= RST_ZERO;
        end else begin
            sync_mask_q <= sync_mask_d;
            cmm_en_q <= cmm_en_d;
            error_limit_q <= error_limit_d;
            lane_on_bits_q <= lane_on_bits_d;
            ramp_verify_on_q <= ramp_verify_on_d;
            constant_level_test_on_q <= constant_level_test_on_d;
            dig_spare_q <= dig_spare_d;
            i_level_low_byte_q <= i_level_low_byte_d;
            i_level_high_byte_q <= i_level_high_byte_d;
            q_level_low_byte_q <= q_level_low_byte_d;
            q_level_high_byte_q <= q_level_high_byte_d;
            irq_en_q <= irq_en_d;
            rdata_q <= rdata_d;
        end
    end

    // per-lane counters and ramp check; lanes left off stay idle
    genvar l;
    generate
        for (l = 0; l < NLANE; l++) begin : g_lane
            logic [2:0] err;
            logic [7:0] octet;
            assign err = {lane_err_i.ucc[l], lane_err_i.nit[l], lane_err_i.disp[l]};
            assign octet = ilas_data_i[8*l +: 8];
            for (genvar k = 0; k < NKIND; k++) begin : g_kind
                // saturating, so a low limit raised later still trips
                always_comb begin
                    cnt_d[k][l] = cnt_q[k][l];
                    if (counter_clear_i) begin
                        cnt_d[k][l] = RST_ZERO;
                    end else if (lane_on_bits_q[l] && char_valid_i[l] && err[k]) begin
                        cnt_d[k][l] = sat_inc(cnt_q[k][l]);
                    end
                end
                always_ff @(posedge mclk_i or negedge rst_n_i) begin
                    if (!rst_n_i) begin
                        cnt_q[k][l] <= RST_ZERO;
                    end else begin
                        cnt_q[k][l] <= cnt_d[k][l];
                    end
                end
                assign hit[k][l] = lane_on_bits_q[l] && (cnt_q[k][l] >= error_limit_q);
            end
            assign lane_hit[l] = hit[KIND_DISP][l] | hit[KIND_NIT][l] | hit[KIND_UCC][l];

            always_comb begin
                logic [7:0] want;
                want = ilas_first_i[l] ? 8'h00 : exp_q[l];
                exp_d[l] = exp_q[l];
                fail_d[l] = fail_q[l];
                if (counter_clear_i) begin
                    exp_d[l] = RST_ZERO;
                    fail_d[l] = 1'b0;
                end else if (lane_on_bits_q[l] && ilas_valid_i[l]) begin
                    exp_d[l] = want + 8'h01;
                end
                // a bad octet beats a clear in the same cycle, so it is never lost
                // check off: any content accepted
                if (lane_on_bits_q[l] && ilas_valid_i[l] && ramp_verify_on_q
                    && (octet != want)) begin
                    fail_d[l] = 1'b1;
                end
            end
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    exp_q[l] <= RST_ZERO;
                    fail_q[l] <= 1'b0;
                end else begin
                    exp_q[l] <= exp_d[l];
                    fail_q[l] <= fail_d[l];
                end
            end
        end
    endgenerate

    // outputs; level results held until the counters are cleared
    always_comb begin
        resync_d = 1'b0;
        irq_d = 1'b0;
        for (int k = 0; k < NKIND; k++) begin
            if (sync_en[k] && (|hit[k])) begin
                resync_d = 1'b1;
            end
            if (irq_en_q[k] && (|hit[k])) begin
                irq_d = 1'b1;
            end
        end
        // lanes must be set before the sync pattern; a later lane is admitted unless its fail bit is set
        start_ok_d = ~|(fail_q & lane_on_bits_q);
        if (constant_level_test_on_q) begin
            dp_d.i = {i_level_high_byte_q, i_level_low_byte_q};
            dp_d.q = {q_level_high_byte_q, q_level_low_byte_q};
        end else begin
            dp_d = dp_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resync_q <= 1'b0;
            irq_q <= 1'b0;
            start_ok_q <= 1'b0;
            dp_q <= '0;
        end else begin
            resync_q <= resync_d;
            irq_q <= irq_d;
            start_ok_q <= start_ok_d;
            dp_q <= dp_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign resync_request_out_o = resync_q;
    assign error_irq_o = irq_q;
    assign ilas_fail_o = fail_q;
    assign link_start_ok_o = start_ok_q;
    assign dp_data_o = dp_q;
endmodule
`default_nettype wire

// File: hdl/jrxc_pkg.sv
// constants and types for the receive link supervision block
`default_nettype none
package jrxc_pkg;
    localparam int NLANE = 8;
    localparam int NKIND = 3;
    localparam int ADDR_W = 12;
    // register offsets
    localparam logic [11:0] OFF_SYNC_MASK = 12'h47b;
    localparam logic [11:0] OFF_ERR_LIMIT = 12'h47c;
    localparam logic [11:0] OFF_LANE_EN = 12'h47d;
    localparam logic [11:0] OFF_RAMP = 12'h47e;
    localparam logic [11:0] OFF_DIG_TEST = 12'h520;
    localparam logic [11:0] OFF_I_LO = 12'h521;
    localparam logic [11:0] OFF_I_HI = 12'h522;
    localparam logic [11:0] OFF_Q_LO = 12'h523;
    localparam logic [11:0] OFF_Q_HI = 12'h524;
    localparam logic [11:0] OFF_IRQ_EN = 12'h4f0;
    localparam logic [11:0] OFF_ILAS_FAIL = 12'h4f1;
    localparam logic [11:0] OFF_LIMIT_HIT = 12'h4f2;
    // field positions
    localparam int SYNC_DISP_BIT = 7;
    localparam int SYNC_NIT_BIT = 6;
    localparam int SYNC_UCC_BIT = 5;
    localparam int CMM_EN_BIT = 3;
    localparam int RAMP_BIT = 0;
    localparam int DC_TEST_BIT = 1;
    localparam int DIG_SPARE_BIT = 0;
    // error kinds, index into counters and irq enable bits
    localparam int KIND_DISP = 0;
    localparam int KIND_NIT = 1;
    localparam int KIND_UCC = 2;
    // reset values and counter saturation value
    localparam logic [7:0] RST_ERR_LIMIT = 8'hff;
    localparam logic [7:0] RST_LANE_EN = 8'h0f;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic RST_CMM_EN = 1'b1;
    localparam logic [7:0] CNT_MAX = 8'hff;

    typedef struct packed {
        logic [7:0] disp;
        logic [7:0] nit;
        logic [7:0] ucc;
    } jrxc_lane_err_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } jrxc_reg_req_t;

    typedef struct packed {
        logic [15:0] i;
        logic [15:0] q;
    } jrxc_iq_t;
endpackage
`default_nettype wire

// File: sim/jrxc_top_asserts.sv
// port assertions for the receive link supervision block
`timescale 1ns/1ps
`default_nettype none
module jrxc_top_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire jrxc_pkg::jrxc_reg_req_t reg_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire jrxc_pkg::jrxc_lane_err_t lane_err_i,
    input wire logic [7:0] char_valid_i,
    input wire logic counter_clear_i,
    input wire logic [7:0] ilas_valid_i,
    input wire jrxc_pkg::jrxc_iq_t dp_data_i,
    input wire jrxc_pkg::jrxc_iq_t dp_data_o,
    input wire logic resync_request_out_o,
    input wire logic error_irq_o,
    input wire logic [7:0] ilas_fail_o,
    input wire logic link_start_ok_o
);
    import jrxc_pkg::*;
    logic any_err;
    assign any_err = |((lane_err_i.disp | lane_err_i.nit | lane_err_i.ucc) & char_valid_i);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_unmapped_rd;
        reg_req_i.rd && reg_req_i.addr[11:8] == 4'h0 ##1 !reg_req_i.rd;
    endsequence
    sequence s_resync_rise;
        $rose(resync_request_out_o);
    endsequence
    sequence s_irq_rise;
        $rose(error_irq_o);
    endsequence
    a_rdata_hold: assert property (!$past(reg_req_i.rd) && !$past(reg_req_i.rd, 2)
        |-> $stable(reg_rdata_o)) else $error("read data moved");
    a_unmapped_zero: assert property (s_unmapped_rd |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_fail_ok: assert property (ilas_fail_o == 8'h00 |=> link_start_ok_o)
        else $error("start blocked without fail");
    a_fail_sticky: assert property (!counter_clear_i |=>
        (ilas_fail_o & $past(ilas_fail_o)) == $past(ilas_fail_o)) else $error("fail lost");
    a_fail_cause: assert property (1'b1 |=>
        (ilas_fail_o & ~$past(ilas_fail_o) & ~$past(ilas_valid_i)) == 8'h00)
        else $error("fail without octet");
    a_resync_cause: assert property (s_resync_rise |-> $past(any_err, 2) ||
        $past(any_err, 3) || $past(reg_req_i.wr) || $past(reg_req_i.wr, 2))
        else $error("resync without cause");
    a_irq_cause: assert property (s_irq_rise |-> $past(any_err, 2) ||
        $past(any_err, 3) || $past(reg_req_i.wr) || $past(reg_req_i.wr, 2))
        else $error("irq without cause");
    a_dp_steady: assert property ($past(rst_n_i) && !$past(reg_req_i.wr) &&
        $stable(dp_data_i) |=> $stable(dp_data_o)) else $error("datapath moved");
endmodule
bind jrxc_top jrxc_top_asserts jrxc_top_asserts_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .lane_err_i(lane_err_i),
    .char_valid_i(char_valid_i), .counter_clear_i(counter_clear_i),
    .ilas_valid_i(ilas_valid_i), .dp_data_i(dp_data_i), .dp_data_o(dp_data_o),
    .resync_request_out_o(resync_request_out_o), .error_irq_o(error_irq_o),
    .ilas_fail_o(ilas_fail_o), .link_start_ok_o(link_start_ok_o));
`default_nettype wire

// File: sim/jrxc_tx_model.sv
// transmitter model: error characters and alignment octets on every lane
`timescale 1ns/1ps
`default_nettype none
module jrxc_tx_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] err_kind_i,
    input wire logic [7:0] err_lane_i,
    input wire logic ramp_go_i,
    input wire logic ramp_bad_i,
    output jrxc_pkg::jrxc_lane_err_t lane_err_o,
    output logic [7:0] char_valid_o,
    output logic [7:0] ilas_valid_o,
    output logic [7:0] ilas_first_o,
    output logic [63:0] ilas_data_o
);
    import jrxc_pkg::*;
    logic [2:0] step_q;
    logic [7:0] last_q;
    logic [7:0] oct;
    assign char_valid_o = 8'hff;
    assign lane_err_o.disp = err_kind_i[KIND_DISP] ? err_lane_i : 8'h00;
    assign lane_err_o.nit = err_kind_i[KIND_NIT] ? err_lane_i : 8'h00;
    assign lane_err_o.ucc = err_kind_i[KIND_UCC] ? err_lane_i : 8'h00;
    // ramp 00-01-02-03, third octet spoiled on command
    assign oct = (ramp_bad_i && step_q == 3'h3) ? 8'h05 : {5'h00, step_q} - 8'h01;
    assign ilas_valid_o = (step_q != 3'h0) ? 8'hff : 8'h00;
    assign ilas_first_o = (step_q == 3'h1) ? 8'hff : 8'h00;
    // idle lines show the inverse so a stale octet never looks valid
    assign ilas_data_o = (step_q != 3'h0) ? {8{oct}} : {8{~last_q}};
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_q <= 3'h0;
            last_q <= 8'h00;
        end else begin
            if (step_q != 3'h0 || ramp_go_i) step_q <= (step_q == 3'h4) ? 3'h0 : step_q + 3'h1;
            if (step_q != 3'h0) last_q <= oct;
        end
    end
endmodule
`default_nettype wire

// File: sim/jrxc_top_tb.sv
// self-checking bench for the receive link supervision block
`timescale 1ns/1ps
`default_nettype none
module jrxc_top_tb;
    import jrxc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n = 1'b0;
    logic clr = 1'b0;
    logic go = 1'b0;
    logic bad = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [7:0] lane = 8'h00;
    jrxc_reg_req_t req = '0;
    jrxc_iq_t dpi = 32'hbeefcafe;
    jrxc_iq_t dpo;
    jrxc_lane_err_t lerr;
    logic [7:0] cval, ivld, ifst, rdata, fail;
    logic [63:0] idat;
    logic rsy, irq, ok;
    int error_cnt = 0;
    int checked = 0;
    logic [11:0] ra [10] = '{12'h47b, 12'h47c, 12'h0a5, 12'h47d, 12'h47e, 12'h520, 12'h521,
        12'h522, 12'h523, 12'h524};
    logic [7:0] rv [10] = '{8'h08, 8'hff, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};
    always #5 mclk_i = ~mclk_i;
    jrxc_top jrxc_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n), .reg_req_i(req),
        .reg_rdata_o(rdata), .lane_err_i(lerr), .char_valid_i(cval), .counter_clear_i(clr),
        .ilas_valid_i(ivld), .ilas_first_i(ifst), .ilas_data_i(idat), .dp_data_i(dpi),
        .dp_data_o(dpo), .resync_request_out_o(rsy), .error_irq_o(irq), .ilas_fail_o(fail),
        .link_start_ok_o(ok));
    jrxc_tx_model jrxc_tx_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n), .err_kind_i(kind),
        .err_lane_i(lane), .ramp_go_i(go), .ramp_bad_i(bad), .lane_err_o(lerr),
        .char_valid_o(cval), .ilas_valid_o(ivld), .ilas_first_o(ifst), .ilas_data_o(idat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk_i);
        req.wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk_i);
        req.rd = 1'b0;
        @(negedge mclk_i);
        chk(rdata, exp);
    endtask
    task automatic err(input logic [2:0] k, input logic [7:0] l);
        @(negedge mclk_i);
        kind = k;
        lane = l;
        @(negedge mclk_i);
        kind = 3'h0;
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic pulse_clr;
        @(negedge mclk_i);
        clr = 1'b1;
        @(negedge mclk_i);
        clr = 1'b0;
    endtask
    task automatic ramp(input logic b);
        @(negedge mclk_i);
        go = 1'b1;
        bad = b;
        @(negedge mclk_i);
        go = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #100us;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (20) @(negedge mclk_i);
        rst_n = 1'b1;
        for (int n = 0; n < 10; n++) rd(ra[n], rv[n]);
        wr(12'h4f1, 8'hff);
        rd(12'h4f1, 8'h00);
        $display("test registers done");
        wr(12'h47c, 8'h02);
        rd(12'h47c, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wr(12'h47b, p ? 8'ha0 : 8'h40);
            wr(12'h4f0, p ? 8'h02 : 8'h05);
            rd(12'h47b, p ? 8'ha0 : 8'h40);
            for (int k = 0; k < 3; k++) begin
                pulse_clr();
                err(3'h1 << k, 8'h03);
                chk({rsy, irq}, 2'b00);
                err(3'h1 << k, 8'h01);
                chk({rsy, irq}, {(k == 1) ^ p[0], (k != 1) ^ p[0]});
            end
        end
        pulse_clr();
        repeat (2) err(3'h1, 8'h20);
        chk(rsy, 1'b0);
        wr(12'h47d, 8'h2f);
        repeat (2) err(3'h1, 8'h20);
        chk(rsy, 1'b1);
        rd(12'h4f2, 8'h20);
        pulse_clr();
        @(negedge mclk_i);
        chk(rsy, 1'b0);
        $display("test errors done");
        ramp(1'b1);
        chk({fail, ok}, 9'h001);
        wr(12'h47e, 8'h01);
        ramp(1'b0);
        chk({fail, ok}, 9'h001);
        ramp(1'b1);
        chk({fail, ok}, 9'h05e);
        rd(12'h4f1, 8'h2f);
        pulse_clr();
        chk(fail, 8'h00);
        $display("test ramp done");
        wr(12'h521, 8'h34);
        wr(12'h522, 8'h12);
        wr(12'h523, 8'h78);
        wr(12'h524, 8'h56);
        chk(dpo, dpi);
        wr(12'h520, 8'h03);
        @(negedge mclk_i);
        chk(dpo, 32'h12345678);
        rd(12'h520, 8'h03);
        wr(12'h520, 8'h00);
        @(negedge mclk_i);
        chk(dpo, dpi);
        $display("test dc level done");
        rst_n = 1'b0;
        repeat (2) @(negedge mclk_i);
        rst_n = 1'b1;
        rd(12'h47c, 8'hff);
        rd(12'h47d, 8'h0f);
        chk(ok, 1'b1);
        $display("test mid reset done");
        test_done();
    end
endmodule
`default_nettype wire
